// ---- ebc_bus_ctrl.sv ----
// Multiplexed external bus controller with four chip-select channels.
// Assumes one system clock, a simple register port and a single
// outstanding request from the internal master.
//
// The register offsets and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
`include "ebc_params.svh"

module ebc_bus_ctrl #(
   parameter int CHANNELS = `EBC_CHANNELS
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [5:0] regAddr,
   input wire logic [31:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   output logic [31:0] regRdata,
   input wire logic reqValid,
   input wire logic reqWrite,
   input wire logic [31:0] reqAddr,
   input wire ebc_pkg::ebc_size_t reqSize,
   input wire logic [31:0] reqWdata,
   output logic reqReady,
   output logic reqDone,
   output logic reqExternal,
   output logic [31:0] reqRdata,
   output logic [7:0] upperAddressLines,
   output logic [15:0] muxedAddrDataOut,
   output logic muxedAddrDataOe,
   input wire logic [15:0] muxedAddrDataIn,
   output logic latchStrobe,
   output logic readStrobeN,
   output logic writeStrobeN,
   output logic [CHANNELS-1:0] chipSelN
);
   import ebc_pkg::*;

   logic [31:0] chipSelectTimingControl_reg [CHANNELS];
   logic [31:0] windowConfig_reg [CHANNELS];
   logic [31:0] regRdata_reg;
   ebc_state_t state_reg, state_next;
   logic [4:0] cnt_reg, cnt_next;
   logic [4:0] recov_reg, recov_next;
   logic [1:0] chan_reg, chan_next;
   logic wr_reg;
   ebc_size_t size_reg;
   logic [2:0] beats_reg, beats_next;
   logic [31:0] addr_reg, wShift_reg, rAcc_reg;
   logic done_reg, done_next, ext_reg;
   logic [31:0] reqRdata_reg;
   logic [15:0] adMeta_reg, adSync_reg;
   logic [7:0] upper_reg;
   logic [15:0] adOut_reg;
   logic adOe_reg, ale_reg, rdN_reg, wrN_reg;
   logic [CHANNELS-1:0] csN_reg;

   // Two-bit code table shared by setup, latch wait and cs recovery
   function automatic logic [4:0] code2(input logic [1:0] c);
      return (c == 2'h3) ? 5'h04 : {3'h0, c};
   endfunction

   // Recovery table: 0..6 direct, top code means eight
   function automatic logic [4:0] code3(input logic [2:0] c);
      return (c == 3'h7) ? 5'h08 : {2'h0, c};
   endfunction

   // Register port decode
   logic [3:0] regIdx;
   logic ctlSel, winSel, statSel;
   assign regIdx = regAddr[5:2];
   assign ctlSel = (regAddr[5:4] == 2'(`EBC_OFS_CTL0 >> 4));
   assign winSel = (regAddr[5:4] == 2'(`EBC_OFS_WIN0 >> 4));
   assign statSel = (regAddr == `EBC_OFS_STAT);

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         for (int i = 0; i < CHANNELS; i++) begin
            chipSelectTimingControl_reg[i] <= `EBC_CTL_RST;
            windowConfig_reg[i] <= `EBC_WIN_RST;
         end
      end else if (regWr) begin
         if (ctlSel)
            chipSelectTimingControl_reg[regIdx[1:0]] <=
               regWdata & `EBC_CTL_WMASK;
         if (winSel)
            windowConfig_reg[regIdx[1:0]] <= regWdata & `EBC_WIN_WMASK;
      end
   end

   logic [31:0] statusWord;
   assign statusWord = {16'h0000, 3'h0, recov_reg, 1'b0, state_reg,
                        2'h0, chan_reg};

   logic [31:0] rdMux;
   assign rdMux = ctlSel ? chipSelectTimingControl_reg[regIdx[1:0]] :
                  winSel ? windowConfig_reg[regIdx[1:0]] :
                  statSel ? statusWord : 32'h0000_0000;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst)
         regRdata_reg <= 32'h0000_0000;
      else
         regRdata_reg <= regRd ? rdMux : 32'h0000_0000;
   end
   assign regRdata = regRdata_reg;

   // Window decode per channel, then fixed priority
   logic [CHANNELS-1:0] hits;
   genvar g;
   generate
      for (g = 0; g < CHANNELS; g++) begin : gWin
         ebc_window_dec uDec (
            .addrHigh(reqAddr[31:`EBC_START_LSB]),
            .windowStart(windowConfig_reg[g][31:`EBC_START_LSB]),
            .windowSizeCode(windowConfig_reg[g][7:0]),
            .channelEnable(chipSelectTimingControl_reg[g][`EBC_ENABLE_BIT]),
            .hit(hits[g])
         );
      end
   endgenerate

   logic [1:0] hitChan;
   always_comb begin
      hitChan = 2'h0;
      for (int i = CHANNELS - 1; i >= 0; i--)
         if (hits[i])
            hitChan = 2'(i);
   end

   // Fields of the channel in use this cycle
   logic accept;
   logic [31:0] ctl;
   logic width16, wrNow;
   logic [4:0] aleWait, setupClks, waitClks, strobeLoad, recovNew;
   assign accept = (state_reg == EBC_IDLE) && reqValid && (|hits);
   assign ctl = chipSelectTimingControl_reg[chan_next];
   assign wrNow = accept ? reqWrite : wr_reg;
   assign width16 = (ctl[`EBC_WIDTH_LSB +: 2] == `EBC_WIDTH16_CODE);
   assign aleWait = code2(ctl[`EBC_LATCH_WAIT_LSB +: 2]);
   assign setupClks = wrNow ? code2(ctl[`EBC_WR_SETUP_LSB +: 2]) :
                      code2(ctl[`EBC_RD_SETUP_LSB +: 2]);
   assign waitClks = {1'b0, ctl[`EBC_WAIT_LSB +: 4]};
   assign strobeLoad = 5'(`EBC_STROBE_CLKS - 1) + waitClks;
   assign recovNew = (wr_reg ? code3(ctl[`EBC_WR_RECOV_LSB +: 3]) :
                      code3(ctl[`EBC_RD_RECOV_LSB +: 3])) +
                     code2(ctl[`EBC_CS_RECOV_LSB +: 2]);

   // Transfer split per data width, little-endian order
   logic [2:0] beatsLoad;
   logic [2:0] beatBytes;
   logic lastBeat, strobeEnd;
   assign beatsLoad = (reqSize == EBC_BYTE) ? 3'h1 :
                      (reqSize == EBC_HALF) ? (width16 ? 3'h1 : 3'h2) :
                      (width16 ? 3'h2 : 3'h4);
   assign beatBytes = (width16 && size_reg != EBC_BYTE) ? 3'h2 : 3'h1;
   assign lastBeat = (beats_reg == 3'h1);
   assign strobeEnd = (state_reg == EBC_STROBE) && (cnt_reg == 5'h00);

   // Sequencer
   always_comb begin
      state_next = state_reg;
      cnt_next = (cnt_reg != 5'h00) ? cnt_reg - 5'h01 : 5'h00;
      recov_next = recov_reg;
      chan_next = accept ? hitChan : chan_reg;
      beats_next = beats_reg;
      done_next = 1'b0;
      case (state_reg)
         EBC_IDLE: begin
            if (reqValid && !(|hits)) begin
               done_next = 1'b1;
            end else if (accept) begin
               beats_next = beatsLoad;
               // Owed recovery only paid before the next external access
               if (recov_reg != 5'h00) begin
                  state_next = EBC_RECOV;
                  cnt_next = recov_reg - 5'h01;
               end else if (aleWait != 5'h00) begin
                  state_next = EBC_LATCH_WAIT;
                  cnt_next = aleWait - 5'h01;
               end else
                  state_next = EBC_LATCH;
               recov_next = 5'h00;
            end
         end
         EBC_RECOV, EBC_LATCH_WAIT: begin
            if (cnt_reg == 5'h00) begin
               if (state_reg == EBC_RECOV && aleWait != 5'h00) begin
                  state_next = EBC_LATCH_WAIT;
                  cnt_next = aleWait - 5'h01;
               end else
                  state_next = EBC_LATCH;
            end
         end
         EBC_LATCH:
            state_next = EBC_HOLD;
         EBC_HOLD, EBC_SETUP: begin
            if (state_reg == EBC_HOLD && setupClks != 5'h00) begin
               state_next = EBC_SETUP;
               cnt_next = setupClks - 5'h01;
            end else if (cnt_reg == 5'h00) begin
               state_next = EBC_STROBE;
               cnt_next = strobeLoad;
            end
         end
         EBC_STROBE: begin
            if (cnt_reg == 5'h00) begin
               beats_next = beats_reg - 3'h1;
               if (lastBeat) begin
                  state_next = EBC_IDLE;
                  done_next = 1'b1;
                  recov_next = recovNew;
               end else if (recovNew != 5'h00) begin
                  state_next = EBC_RECOV;
                  cnt_next = recovNew - 5'h01;
               end else if (aleWait != 5'h00) begin
                  state_next = EBC_LATCH_WAIT;
                  cnt_next = aleWait - 5'h01;
               end else
                  state_next = EBC_LATCH;
            end
         end
         default:
            state_next = EBC_IDLE;
      endcase
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_reg <= EBC_IDLE;
         cnt_reg <= 5'h00;
         recov_reg <= 5'h00;
         chan_reg <= 2'h0;
         beats_reg <= 3'h0;
         done_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         recov_reg <= recov_next;
         chan_reg <= chan_next;
         beats_reg <= beats_next;
         done_reg <= done_next;
      end
   end

   // Read data pass two flops; sampling lags the pins by two clocks,
   // so every read needs at least one wait to cover that latency.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         adMeta_reg <= 16'h0000;
         adSync_reg <= 16'h0000;
      end else begin
         adMeta_reg <= muxedAddrDataIn;
         adSync_reg <= adMeta_reg;
      end
   end

   logic [7:0] rdByte;
   logic [31:0] rAccNew, rAligned, addrInc;
   logic [4:0] alignShift;
   assign rdByte = (width16 && addr_reg[0]) ? adSync_reg[15:8] :
                   adSync_reg[7:0];
   assign rAccNew = (beatBytes == 3'h2) ? {adSync_reg, rAcc_reg[31:16]} :
                    {rdByte, rAcc_reg[31:8]};
   assign alignShift = (size_reg == EBC_BYTE) ? 5'h18 :
                       (size_reg == EBC_HALF) ? 5'h10 : 5'h00;
   assign rAligned = rAccNew >> alignShift;
   assign addrInc = addr_reg + {29'h0, beatBytes};

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         wr_reg <= 1'b0;
         size_reg <= EBC_BYTE;
         addr_reg <= 32'h0000_0000;
         wShift_reg <= 32'h0000_0000;
         rAcc_reg <= 32'h0000_0000;
         reqRdata_reg <= 32'h0000_0000;
         ext_reg <= 1'b0;
      end else if (accept) begin
         wr_reg <= reqWrite;
         size_reg <= reqSize;
         addr_reg <= reqAddr;
         wShift_reg <= reqWdata;
         ext_reg <= 1'b1;
      end else if (state_reg == EBC_IDLE && reqValid) begin
         ext_reg <= 1'b0;
         reqRdata_reg <= 32'h0000_0000;
      end else if (strobeEnd) begin
         addr_reg <= addrInc;
         wShift_reg <= wShift_reg >> {beatBytes, 3'h0};
         rAcc_reg <= rAccNew;
         if (lastBeat && !wr_reg)
            reqRdata_reg <= rAligned;
      end
   end

   // Pin drive follows the next state so pins line up with the state
   logic addrPhase, dataPhase, csOn;
   logic [15:0] wrData;
   assign addrPhase = (state_next == EBC_LATCH_WAIT) ||
                      (state_next == EBC_LATCH) ||
                      (state_next == EBC_HOLD);
   assign dataPhase = (state_next == EBC_SETUP) ||
                      (state_next == EBC_STROBE);
   assign csOn = addrPhase || dataPhase;
   assign wrData = (size_reg == EBC_BYTE) ?
                   {wShift_reg[7:0], wShift_reg[7:0]} : wShift_reg[15:0];

   logic [31:0] addrNow;
   // Address steps at a strobe end, so a latch right after shows the new one
   assign addrNow = accept ? reqAddr : strobeEnd ? addrInc : addr_reg;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         upper_reg <= 8'h00;
         adOut_reg <= 16'h0000;
         adOe_reg <= 1'b0;
         ale_reg <= 1'b0;
         rdN_reg <= 1'b1;
         wrN_reg <= 1'b1;
         csN_reg <= '1;
      end else begin
         if (addrPhase) begin
            upper_reg <= addrNow[23:16];
            adOut_reg <= addrNow[15:0];
         end else if (dataPhase && wrNow)
            adOut_reg <= wrData;
         // Internal cycles leave the bus floating and strobes idle
         adOe_reg <= addrPhase || (dataPhase && wrNow);
         ale_reg <= (state_next == EBC_LATCH);
         rdN_reg <= !((state_next == EBC_STROBE) && !wrNow);
         wrN_reg <= !((state_next == EBC_STROBE) && wrNow);
         for (int i = 0; i < CHANNELS; i++)
            csN_reg[i] <= !(csOn && chan_next == 2'(i) &&
               chipSelectTimingControl_reg[i][`EBC_ENABLE_BIT]);
      end
   end

   assign upperAddressLines = upper_reg;
   assign muxedAddrDataOut = adOut_reg;
   assign muxedAddrDataOe = adOe_reg;
   assign latchStrobe = ale_reg;
   assign readStrobeN = rdN_reg;
   assign writeStrobeN = wrN_reg;
   assign chipSelN = csN_reg;
   assign reqReady = (state_reg == EBC_IDLE);
   assign reqDone = done_reg;
   assign reqExternal = ext_reg;
   assign reqRdata = reqRdata_reg;
endmodule

// ---- ebc_params.svh ----
// Constants for the multiplexed external bus controller: register
// offsets, field positions, reset values and cycle counts.
// Assumes inclusion by bare name from the design files.
`ifndef EBC_PARAMS_SVH
`define EBC_PARAMS_SVH

`define EBC_CHANNELS 4
`define EBC_OFS_CTL0 6'h00
`define EBC_OFS_WIN0 6'h10
`define EBC_OFS_STAT 6'h20

`define EBC_CTL_RST 32'h4915_0202
`define EBC_CTL_WMASK 32'hFF3F_1F0F
`define EBC_WIN_RST 32'h0000_0000
`define EBC_WIN_WMASK 32'hFFFF_00FF

`define EBC_CS_RECOV_LSB 30
`define EBC_WR_RECOV_LSB 27
`define EBC_RD_RECOV_LSB 24
`define EBC_LATCH_WAIT_LSB 20
`define EBC_WR_SETUP_LSB 18
`define EBC_RD_SETUP_LSB 16
`define EBC_WAIT_LSB 8
`define EBC_WIDTH_LSB 1
`define EBC_ENABLE_BIT 0
`define EBC_WIDTH16_CODE 2'h1

`define EBC_START_LSB 16
`define EBC_SIZE_MAX 8'h08
`define EBC_BASE_CMP_BITS 8

`define EBC_BASIC_CLKS 4
`define EBC_ADDR_CLKS 2
`define EBC_STROBE_CLKS (`EBC_BASIC_CLKS - `EBC_ADDR_CLKS)

`endif

// ---- ebc_pkg.sv ----
// Types shared by the external bus controller files.
// No assumptions beyond a SystemVerilog compiler.
package ebc_pkg;
   typedef enum logic [2:0] {
      EBC_IDLE = 3'b000,
      EBC_RECOV = 3'b001,
      EBC_LATCH_WAIT = 3'b010,
      EBC_LATCH = 3'b011,
      EBC_HOLD = 3'b100,
      EBC_SETUP = 3'b101,
      EBC_STROBE = 3'b110
   } ebc_state_t;

   typedef enum logic [1:0] {
      EBC_BYTE = 2'b00,
      EBC_HALF = 2'b01,
      EBC_WORD = 2'b10
   } ebc_size_t;
endpackage

// ---- ebc_window_dec.sv ----
// Address window decoder for one chip-select channel.
// Assumes the start address and size code come straight from registers.
`timescale 1ns/1ps
`include "ebc_params.svh"

module ebc_window_dec (
   input wire logic [15:0] addrHigh,
   input wire logic [15:0] windowStart,
   input wire logic [7:0] windowSizeCode,
   input wire logic channelEnable,
   output logic hit
);
   logic [4:0] cmpBits;
   logic [15:0] cmpMask;
   logic codeLegal;

   // Size code n compares the top 8+n address bits
   assign codeLegal = (windowSizeCode <= `EBC_SIZE_MAX);
   assign cmpBits = 5'(`EBC_BASE_CMP_BITS) + windowSizeCode[4:0];
   assign cmpMask = ~(16'hFFFF >> cmpBits);
   // Prohibited codes never hit, so a bad setting cannot drive a pin
   assign hit = channelEnable && codeLegal &&
      ((addrHigh & cmpMask) == (windowStart & cmpMask));
endmodule

// ---- ebc_bus_ctrl_properties.sv ----
// Pin timing properties of the external bus controller.
// Assumes a bind to ebc_bus_ctrl and sight of its ports only.
`timescale 1ns/1ps
module ebc_bus_ctrl_properties #(
   parameter int CHANNELS = 4
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic reqReady,
   input wire logic reqDone,
   input wire logic reqExternal,
   input wire logic [7:0] upperAddressLines,
   input wire logic muxedAddrDataOe,
   input wire logic latchStrobe,
   input wire logic readStrobeN,
   input wire logic writeStrobeN,
   input wire logic [CHANNELS-1:0] chipSelN
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);
   logic csOn;
   assign csOn = (chipSelN != '1);
   AST_ONE_CS: assert property ($onehot0(~chipSelN))
      else $error("two chip selects active");
   AST_ALE_PULSE: assert property (latchStrobe |=> !latchStrobe)
      else $error("latch strobe longer than one clock");
   AST_ALE_DRIVE: assert property (
      latchStrobe |-> csOn && muxedAddrDataOe)
      else $error("latch strobe without select or address");
   AST_ALE_HOLD: assert property (
      latchStrobe |=> readStrobeN && writeStrobeN)
      else $error("strobe right after latch");
   AST_ALE_STROBE: assert property (
      latchStrobe |-> ##[2:6] (!readStrobeN || !writeStrobeN))
      else $error("strobe not within setup range");
   AST_RD_BUS: assert property (
      !readStrobeN |-> !muxedAddrDataOe && writeStrobeN)
      else $error("shared lines driven during read");
   AST_RD_MIN: assert property ($fell(readStrobeN) |=> !readStrobeN)
      else $error("read strobe shorter than two clocks");
   AST_CS_TO_ALE: assert property ($rose(csOn) |-> ##[0:4] latchStrobe)
      else $error("latch strobe late after select");
   AST_INTERNAL: assert property (
      reqDone && !reqExternal |-> $stable(upperAddressLines) && !csOn
         && !latchStrobe && !muxedAddrDataOe)
      else $error("pins moved for internal access");
   AST_DONE_READY: assert property (reqDone |-> reqReady)
      else $error("not ready when done");
   cover property (!readStrobeN);
   cover property (!writeStrobeN);
   cover property (reqDone && !reqExternal);
endmodule

bind ebc_bus_ctrl ebc_bus_ctrl_properties #(.CHANNELS(CHANNELS)) uProps (
   .clk(clk), .sys_rst(sys_rst), .reqReady(reqReady), .reqDone(reqDone),
   .reqExternal(reqExternal), .upperAddressLines(upperAddressLines),
   .muxedAddrDataOe(muxedAddrDataOe), .latchStrobe(latchStrobe),
   .readStrobeN(readStrobeN), .writeStrobeN(writeStrobeN),
   .chipSelN(chipSelN));

// ---- ebc_mem_model.sv ----
// Behavioural memory on the far side of the multiplexed bus.
// Assumes one select line, low while any channel is active.
`timescale 1ns/1ps
module ebc_mem_model (
   input wire logic clk,
   input wire logic csN,
   input wire logic [7:0] upperAddr,
   input wire logic [15:0] busOut,
   input wire logic busOe,
   input wire logic latch,
   input wire logic rdN,
   input wire logic wrN,
   output logic [15:0] busIn,
   output logic [23:0] addrSeen
);
   logic [15:0] mem [256];
   logic [15:0] lastVal = 16'h0000;
   logic reading;
   initial begin
      addrSeen = 24'h00_0000;
      for (int i = 0; i < 256; i++) mem[i] = 16'h0000;
   end
   assign reading = !rdN && !csN && !busOe;
   // Released lines flip each clock so stale data cannot pass
   assign busIn = busOe ? busOut :
      (reading ? mem[addrSeen[7:0]] : ~lastVal);
   always @(posedge clk) begin
      if (latch && !csN) addrSeen <= {upperAddr, busOut};
      if (!wrN && !csN) mem[addrSeen[7:0]] <= busOut;
      lastVal <= busIn;
   end
endmodule

// ---- ebc_tb.sv ----
// Self-checking bench for the multiplexed external bus controller.
// Assumes ebc_bus_ctrl, its bound checker and ebc_mem_model.
`timescale 1ns/1ps
`define CHK(g, e) begin \
   check_count++; \
   if ((g) !== (e)) begin \
      n_mismatch++; \
      $display("unexpected at %0t: got %0h expected %0h", $time, g, e); \
   end \
end
module testbench;
   import ebc_pkg::*;
   logic clk = 1'h0;
   logic sys_rst = 1'h1;
   logic [5:0] regAddr = 6'h00;
   logic [31:0] regWdata = 32'h0;
   logic regWr = 1'h0;
   logic regRd = 1'h0;
   logic reqValid = 1'h0;
   logic reqWrite = 1'h0;
   logic [31:0] reqAddr = 32'h0;
   ebc_size_t reqSize = EBC_BYTE;
   logic [31:0] reqWdata = 32'h0;
   logic [31:0] regRdata, reqRdata;
   logic reqReady, reqDone, reqExternal, muxedAddrDataOe, latchStrobe;
   logic readStrobeN, writeStrobeN;
   logic [7:0] upperAddressLines;
   logic [15:0] muxedAddrDataOut, muxedAddrDataIn;
   logic [3:0] chipSelN, csSeen;
   logic [23:0] addrSeen;
   int n_mismatch = 0;
   int check_count = 0;
   int csLow = 0, rdLow = 0, wrLow = 0, aleCnt = 0, cycles = 0;

   ebc_bus_ctrl dut (.clk(clk), .sys_rst(sys_rst), .regAddr(regAddr),
      .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
      .regRdata(regRdata), .reqValid(reqValid), .reqWrite(reqWrite),
      .reqAddr(reqAddr), .reqSize(reqSize), .reqWdata(reqWdata),
      .reqReady(reqReady), .reqDone(reqDone), .reqExternal(reqExternal),
      .reqRdata(reqRdata), .upperAddressLines(upperAddressLines),
      .muxedAddrDataOut(muxedAddrDataOut),
      .muxedAddrDataOe(muxedAddrDataOe), .muxedAddrDataIn(muxedAddrDataIn),
      .latchStrobe(latchStrobe), .readStrobeN(readStrobeN),
      .writeStrobeN(writeStrobeN), .chipSelN(chipSelN));
   ebc_mem_model memModel (.clk(clk), .csN(&chipSelN),
      .upperAddr(upperAddressLines), .busOut(muxedAddrDataOut),
      .busOe(muxedAddrDataOe), .latch(latchStrobe), .rdN(readStrobeN),
      .wrN(writeStrobeN), .busIn(muxedAddrDataIn), .addrSeen(addrSeen));

   initial forever #2 clk = ~clk;
   always @(posedge clk) begin
      if (chipSelN != 4'hF) csLow++;
      if (!readStrobeN) rdLow++;
      if (!writeStrobeN) wrLow++;
      if (latchStrobe) begin
         aleCnt++;
         csSeen = chipSelN;
      end
      cycles++;
      if (cycles == 20000) begin
         n_mismatch++;
         close_out();
      end
   end

   function automatic int sel4(input int c);
      return (c == 3) ? 4 : c;
   endfunction
   function automatic int rec8(input int c);
      return (c == 7) ? 8 : c;
   endfunction
   task automatic close_out();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic reg_wr(input logic [5:0] a, input logic [31:0] v);
      @(posedge clk);
      regAddr <= a;
      regWdata <= v;
      regWr <= 1'h1;
      @(posedge clk);
      regWr <= 1'h0;
   endtask
   task automatic reg_rd(input logic [5:0] a, output logic [31:0] v);
      @(posedge clk);
      regAddr <= a;
      regRd <= 1'h1;
      @(posedge clk);
      regRd <= 1'h0;
      #1;
      v = regRdata;
   endtask
   // Counters cleared just before the taking edge, while pins are idle
   task automatic access(input logic w, input logic [31:0] a,
         input ebc_size_t s, input logic [31:0] wd,
         output logic [31:0] rd, output int lat);
      @(posedge clk);
      reqValid <= 1'h1;
      reqWrite <= w;
      reqAddr <= a;
      reqSize <= s;
      reqWdata <= wd;
      lat = 0;
      #1;
      while (reqReady !== 1'h1 && lat < 100) begin
         @(posedge clk);
         #1;
         lat++;
      end
      if (lat >= 100) n_mismatch++;
      csLow = 0;
      rdLow = 0;
      wrLow = 0;
      aleCnt = 0;
      lat = 0;
      @(posedge clk);
      reqValid <= 1'h0;
      #1;
      while (reqDone !== 1'h1 && lat < 200) begin
         @(posedge clk);
         #1;
         lat++;
      end
      if (lat >= 200) n_mismatch++;
      rd = reqRdata;
   endtask

   initial begin
      logic [31:0] d, ctl;
      int lat, lb, w;
      repeat (10) @(posedge clk);
      sys_rst <= 1'h0;
      reg_rd(6'h00, d);
      `CHK(d, 32'h4915_0202)
      reg_wr(6'h0C, 32'hFFFF_FFFF);
      reg_rd(6'h0C, d);
      `CHK(d, 32'hFF3F_1F0F)
      reg_wr(6'h24, 32'hFFFF_FFFF);
      reg_rd(6'h24, d);
      `CHK(d, 32'h0000_0000)
      reg_wr(6'h0C, 32'h0000_0000);
      reg_wr(6'h10, 32'h6000_0008);
      $display("registers done");
      for (int i = 0; i < 4; i++) begin
         w = (i == 2) ? 15 : 2 + i;
         ctl = (i << 20) | ((3 - i) << 18) | (i << 16) | (w << 8) | 3;
         reg_wr(6'h00, ctl);
         access(1'h1, 32'h6000_0010 + 2 * i, EBC_HALF, 32'hA5C0 + i, d, lat);
         `CHK(csLow, sel4(i) + sel4(3 - i) + 4 + w)
         `CHK(wrLow, 2 + w)
         `CHK(aleCnt, 1)
         `CHK(addrSeen, 24'h00_0010 + 2 * i)
         access(1'h0, 32'h6000_0010 + 2 * i, EBC_HALF, 32'h0, d, lat);
         `CHK(csLow, 2 * sel4(i) + 4 + w)
         `CHK(rdLow, 2 + w)
         `CHK(d[15:0], 16'hA5C0 + i)
      end
      $display("timing done");
      reg_wr(6'h00, 32'h0000_0203);
      access(1'h0, 32'h6000_0020, EBC_HALF, 32'h0, d, lat);
      access(1'h0, 32'h6000_0020, EBC_HALF, 32'h0, d, lb);
      for (int k = 0; k < 8; k++) begin
         ctl = 32'h0000_0203 | (k << 24) | ((7 - k) << 27) | ((k % 4) << 30);
         reg_wr(6'h00, ctl);
         access(1'h1, 32'h6000_0020, EBC_HALF, 32'h1111, d, lat);
         access(1'h0, 32'h6000_0020, EBC_HALF, 32'h0, d, lat);
         `CHK(lat - lb, rec8(7 - k) + sel4(k % 4))
         access(1'h0, 32'h6000_0020, EBC_HALF, 32'h0, d, lat);
         `CHK(lat - lb, rec8(k) + sel4(k % 4))
      end
      reg_wr(6'h00, 32'h3800_0203);
      access(1'h1, 32'h6000_0020, EBC_HALF, 32'h2222, d, lat);
      reg_rd(6'h20, d);
      `CHK(d, 32'h0000_0800)
      access(1'h0, 32'h1000_0000, EBC_WORD, 32'h0, d, lat);
      `CHK(aleCnt, 0)
      access(1'h0, 32'h6000_0020, EBC_HALF, 32'h0, d, lat);
      `CHK(lat - lb, 8)
      $display("recovery done");
      reg_wr(6'h00, 32'h0000_0201);
      access(1'h1, 32'h6000_0040, EBC_WORD, 32'h1234_5678, d, lat);
      `CHK(aleCnt, 4)
      `CHK({memModel.mem[67][7:0], memModel.mem[64][7:0]}, 16'h1278)
      access(1'h0, 32'h6000_0040, EBC_WORD, 32'h0, d, lat);
      `CHK(d, 32'h1234_5678)
      reg_wr(6'h00, 32'h0000_0203);
      access(1'h1, 32'h6000_0080, EBC_WORD, 32'hCAFE_F00D, d, lat);
      `CHK({memModel.mem[130], memModel.mem[128]}, 32'hCAFE_F00D)
      access(1'h1, 32'h6000_0084, EBC_BYTE, 32'h0000_003C, d, lat);
      `CHK(memModel.mem[132], 16'h3C3C)
      $display("width done");
      reg_wr(6'h00, 32'h0000_0202);
      access(1'h1, 32'h6000_0000, EBC_BYTE, 32'h0, d, lat);
      `CHK(reqExternal, 1'h0)
      reg_wr(6'h14, 32'h6000_0008);
      reg_wr(6'h04, 32'h0000_0203);
      access(1'h1, 32'h6000_0000, EBC_BYTE, 32'h0, d, lat);
      `CHK(csSeen, 4'hD)
      reg_wr(6'h00, 32'h0000_0203);
      access(1'h1, 32'h6000_0000, EBC_BYTE, 32'h0, d, lat);
      `CHK(csSeen, 4'hE)
      access(1'h1, 32'h6001_0000, EBC_BYTE, 32'h0, d, lat);
      `CHK(reqExternal, 1'h0)
      reg_wr(6'h10, 32'h6000_0000);
      access(1'h1, 32'h6001_0000, EBC_BYTE, 32'h0, d, lat);
      `CHK(addrSeen, 24'h01_0000)
      $display("windows done");
      close_out();
   end
endmodule
